// file: hw/dbx_exec_ctrl.sv
// dbx_exec_ctrl: stop-mode execution control, break sources and
// interrupt gating for one cpu core, with the program-address comparators
// assumes commands, watchpoint and pipeline signals on clk; pins are raw
//
// Contract
// - break suspends at next interrupt boundary
// - suspended core ignores all interrupts
// - halt from debug-enabled run on break, or from free-run on user halt
// - address breakpoint halts before second decode
// - soft halt opcode halts before second decode
// - watchpoint request may halt the core
// - external triggers configurable to halt
// - one pending instance per interrupt while halted
// - step runs exactly one packet then halts
// - step services interrupts only when permitted
// - run command services interrupts until break
// - debug event beats interrupt; defer if busy
// - free-run ignores breakpoints, watchpoints, triggers
// - synchronous run waits for global sync
// - soft halt is nop without debugger
// - parameterised count of identical comparators
// - comparator matches address under bit mask
// - address match halts before execution
`timescale 1ns/100ps
`default_nettype none

module dbx_exec_ctrl #(
    parameter int unsigned ADDR_W  = dbx_pkg::DEF_ADDR_W,
    parameter int unsigned NUM_CMP = dbx_pkg::DEF_NUM_CMP,
    parameter int unsigned NUM_INT = dbx_pkg::DEF_NUM_INT
) (
    input  wire logic                             clk,
    input  wire logic                             rst,
    input  wire dbx_pkg::dbx_cmd_s                cmd,
    input  wire dbx_pkg::dbx_cfg_s                cfg,
    input  wire dbx_pkg::dbx_pin_s                pins,
    input  wire logic                             wp_req,
    input  wire logic                             d2_valid,
    input  wire logic [ADDR_W-1:0]                d2_pc,
    input  wire logic                             d2_soft_halt,
    input  wire logic                             ib_boundary,
    input  wire logic                             int_busy,
    input  wire logic [NUM_INT-1:0]               int_req,
    input  wire logic [NUM_INT-1:0]               int_ack,
    input  wire logic [NUM_CMP-1:0]               cmp_en,
    input  wire logic [NUM_CMP-1:0][ADDR_W-1:0]   cmp_ref,
    input  wire logic [NUM_CMP-1:0][ADDR_W-1:0]   cmp_mask,
    output logic                                  d2_go,
    output logic                                  int_svc,
    output logic [NUM_INT-1:0]                    int_pend,
    output logic                                  int_lost,
    output logic                                  running,
    output logic                                  halted,
    output logic                                  stepping,
    output logic                                  sync_wait,
    output logic                                  free_run,
    output dbx_pkg::dbx_cause_s                   cause,
    output logic [NUM_CMP-1:0]                    bp_hit
);

    // refuse sizes the logic cannot serve
    if (ADDR_W < 2 || NUM_CMP < 1 || NUM_INT < 2) begin : g_bad_cfg
        $error("dbx_exec_ctrl: ADDR_W>=2, NUM_CMP>=1, NUM_INT>=2");
    end

    // whole state of the block
    typedef struct packed {
        dbx_pkg::dbx_state_e fsm;         // execution state
        dbx_pkg::dbx_pin_s   s1;          // pin sync, first stage
        dbx_pkg::dbx_pin_s   s2;          // pin sync, second stage
        logic                step_permit; // latched with the step
        logic                step_issued; // the stepped packet has gone
        logic [NUM_INT-1:0]  int_pend;    // one pending per source
        logic                int_lost;    // duplicate dropped
        logic                d2_go;       // packet may enter stage two
        logic                int_svc;     // interrupts may be taken
        logic                running;
        logic                halted;
        logic                stepping;
        logic                sync_wait;
        logic                free_run;
        dbx_pkg::dbx_cause_s cause;       // why the last break happened
        logic [NUM_CMP-1:0]  bp_hit;      // comparators behind it
    } dbx_st_s;

    // state after reset: running, no debugger assumed
    localparam dbx_st_s ST_RST = '{
        fsm:         dbx_pkg::DBX_RUN,
        s1:          '0,
        s2:          '0,
        step_permit: 1'b0,
        step_issued: 1'b0,
        int_pend:    '0,
        int_lost:    1'b0,
        d2_go:       1'b0,
        int_svc:     dbx_pkg::RST_INT_SVC,
        running:     dbx_pkg::RST_RUNNING,
        halted:      1'b0,
        stepping:    1'b0,
        sync_wait:   1'b0,
        free_run:    1'b0,
        cause:       '0,
        bp_hit:      '0
    };

    dbx_st_s            q;        // registered state
    dbx_st_s            d;        // next state
    logic [NUM_CMP-1:0] hit;      // comparator matches this cycle
    logic               cand;     // fresh packet waits for stage two
    logic               conn;     // debugger attached, synchronised
    logic               dbg_on;   // stop mode armed
    logic               swbp;     // soft halt opcode as a break
    logic               hwbp;     // address breakpoint as a break
    logic               wpe;      // watchpoint as a break
    logic               trg;      // external trigger as a break
    logic               brk;      // any break event

    // masked compare: a mask one drops the bit, a zero must match
    function automatic logic addr_match(
        input logic [ADDR_W-1:0] pc,
        input logic [ADDR_W-1:0] ref_a,
        input logic [ADDR_W-1:0] mask
    );
        addr_match = (((pc ^ ref_a) & ~mask) == '0);
    endfunction : addr_match

    // one identical comparator per slot
    for (genvar i = 0; i < NUM_CMP; i++) begin : g_cmp
        assign hit[i] = cmp_en[i] & addr_match(d2_pc, cmp_ref[i], cmp_mask[i]);
    end

    // break sources, all judged before the packet enters stage two
    always_comb begin
        // a packet already granted is not judged again
        cand   = d2_valid & ~q.d2_go;
        conn   = q.s2.dbg_conn;
        dbg_on = cfg.stop_mode_en & conn;
        // soft halt only with a debugger
        swbp   = cand & d2_soft_halt & conn;
        hwbp   = cand & (|hit);
        wpe    = wp_req & cfg.wp_en;
        trg    = q.s2.trig & cfg.trig_en;
        brk    = dbg_on & (cmd.halt | swbp | hwbp | wpe | trg);
    end

    // next state
    always_comb begin
        d         = q;
        // only the second stage reads the first
        d.s1      = pins;
        d.s2      = q.s1;
        d.d2_go   = 1'b0;
        // further copies of a pending source are lost
        d.int_lost = |(int_req & q.int_pend & ~int_ack);
        // a new request wins over an acknowledge in the same cycle
        d.int_pend = (q.int_pend & ~int_ack) | int_req;

        unique case (q.fsm)
            dbx_pkg::DBX_RUN: begin
                if (brk) begin
                    d.fsm    = dbx_pkg::DBX_HPEND;
                    d.cause  = '{user: cmd.halt, swbp: swbp, hwbp: hwbp,
                                 wp: wpe, trig: trg};
                    d.bp_hit = cand ? hit : '0;
                end else if (cand) begin
                    d.d2_go = 1'b1;
                end
            end
            dbx_pkg::DBX_HPEND: begin
                if (ib_boundary && !int_busy) begin
                    d.fsm = dbx_pkg::DBX_HALT;
                end
            end
            dbx_pkg::DBX_HALT: begin
                // step has priority if both arrive together
                if (cmd.step) begin
                    d.fsm         = dbx_pkg::DBX_STEP;
                    d.step_permit = cmd.step_permit;
                    d.step_issued = 1'b0;
                end else if (cmd.run) begin
                    if (cfg.sync_run_en) begin
                        d.fsm = dbx_pkg::DBX_SWAIT;
                    end else if (cfg.stop_mode_en) begin
                        d.fsm = dbx_pkg::DBX_RUN;
                    end else begin
                        d.fsm = dbx_pkg::DBX_FREE;
                    end
                end
            end
            dbx_pkg::DBX_STEP: begin
                if (!q.step_issued && cand) begin
                    d.d2_go       = 1'b1;
                    d.step_issued = 1'b1;
                // the boundary seen while the grant stands is the old one
                end else if (q.step_issued && !q.d2_go && ib_boundary) begin
                    d.fsm = dbx_pkg::DBX_HALT;
                end
            end
            dbx_pkg::DBX_SWAIT: begin
                if (q.s2.gsync) begin
                    d.fsm = cfg.stop_mode_en ? dbx_pkg::DBX_RUN
                                             : dbx_pkg::DBX_FREE;
                end
            end
            dbx_pkg::DBX_FREE: begin
                // only a user halt is heard
                if (cmd.halt && conn) begin
                    d.fsm    = dbx_pkg::DBX_HPEND;
                    d.cause  = '{user: 1'b1, default: 1'b0};
                    d.bp_hit = '0;
                end else if (cand) begin
                    d.d2_go = 1'b1;
                end
            end
            default: begin
                // illegal code: recover to halt, safest for a debugger
                d.fsm = dbx_pkg::DBX_HALT;
            end
        endcase

        // status levels follow the next state so outputs are flops
        d.running   = (d.fsm == dbx_pkg::DBX_RUN);
        d.halted    = (d.fsm == dbx_pkg::DBX_HALT);
        d.stepping  = (d.fsm == dbx_pkg::DBX_STEP);
        d.sync_wait = (d.fsm == dbx_pkg::DBX_SWAIT);
        d.free_run  = (d.fsm == dbx_pkg::DBX_FREE);
        // a break drops the gate first
        d.int_svc   = d.running | d.free_run | (d.stepping & d.step_permit);
    end

    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign d2_go     = q.d2_go;
    assign int_svc   = q.int_svc;
    assign int_pend  = q.int_pend;
    assign int_lost  = q.int_lost;
    assign running   = q.running;
    assign halted    = q.halted;
    assign stepping  = q.stepping;
    assign sync_wait = q.sync_wait;
    assign free_run  = q.free_run;
    assign cause     = q.cause;
    assign bp_hit    = q.bp_hit;

    // checks, all on the cpu clock
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_BOUNDARY_HALT: assert property (
        q.fsm == dbx_pkg::DBX_HPEND && ib_boundary && !int_busy
        |=> halted ##0 !d2_go)
        else $error("break did not halt at boundary");

    AST_HALT_NO_INT: assert property (
        (halted || sync_wait || q.fsm == dbx_pkg::DBX_HPEND) |-> !int_svc)
        else $error("interrupt gate open while suspended");

    AST_BREAK_BLOCKS: assert property (
        q.fsm == dbx_pkg::DBX_RUN && brk
        |=> !d2_go && !int_svc ##1 !d2_go)
        else $error("packet issued after break");

    AST_DEFER_BUSY: assert property (
        q.fsm == dbx_pkg::DBX_HPEND && int_busy |=> !halted)
        else $error("halt taken during interrupt entry");

    AST_PEND_ONE: assert property (
        1'b1 |=> ((int_pend & $past(int_req)) == $past(int_req)))
        else $error("interrupt request not held pending");

    AST_STEP_ONCE: assert property (
        stepping && d2_go |=> !d2_go [*2])
        else $error("more than one packet in a step");

    AST_STEP_GATE: assert property (
        stepping && !q.step_permit |-> !int_svc)
        else $error("step serviced interrupt without permit");

    AST_SYNC_WAIT: assert property (
        sync_wait && !q.s2.gsync && !rst |=> sync_wait && !running)
        else $error("run started before global sync");

    AST_FREE_DEAF: assert property (
        free_run && !cmd.halt |=> free_run && int_svc)
        else $error("free run left on a debug event");

    AST_NOP_GO: assert property (
        running && cand && !brk |=> d2_go)
        else $error("packet held without a break");

    AST_RUN_SVC: assert property (
        running |-> int_svc)
        else $error("run state blocked interrupts");

    AST_SOFT_HALT: assert property (
        running && cand && d2_soft_halt && dbg_on |=> !d2_go && cause.swbp)
        else $error("soft halt opcode let into stage two");

    AST_ADDR_HALT: assert property (
        running && brk && hwbp |=> !d2_go && cause.hwbp && bp_hit == $past(hit))
        else $error("address breakpoint not taken");

    AST_WP_HALT: assert property (
        running && brk && wpe |=> cause.wp && !running)
        else $error("watchpoint request did not halt");

    AST_TRIG_HALT: assert property (
        running && brk && trg |=> cause.trig && !running)
        else $error("external trigger did not halt");

    AST_STEP_SVC: assert property (
        stepping && q.step_permit |-> int_svc)
        else $error("permitted step blocked interrupts");

    AST_LOST_DUP: assert property (
        (|(int_req & int_pend & ~int_ack)) |=> int_lost)
        else $error("duplicate interrupt not reported lost");

endmodule : dbx_exec_ctrl

`default_nettype wire

// file: hw/dbx_pkg.sv
// dbx_pkg: shared types and constants for the debug execution control
// assumes one cpu clock domain; pins arrive raw and are synchronised
package dbx_pkg;

    // default sizes of the top-level parameters
    localparam int unsigned DEF_ADDR_W  = 32;
    localparam int unsigned DEF_NUM_CMP = 4;
    localparam int unsigned DEF_NUM_INT = 8;

    // fixed slots of the interrupt vector
    localparam int unsigned INT_RST_IDX = 0;
    localparam int unsigned INT_NMI_IDX = 1;

    // reset values of the level outputs
    localparam logic RST_RUNNING = 1'b1;
    localparam logic RST_INT_SVC = 1'b1;

    // execution states, one-hot
    typedef enum logic [5:0] {
        DBX_RUN   = 6'h01,  // executing, debug events armed
        DBX_HPEND = 6'h02,  // break taken, waiting for a boundary
        DBX_HALT  = 6'h04,  // debug-halt, nothing executes
        DBX_STEP  = 6'h08,  // one packet in flight
        DBX_SWAIT = 6'h10,  // run accepted, waiting for global sync
        DBX_FREE  = 6'h20   // free-run, debug events other than user halt ignored
    } dbx_state_e;

    // debugger commands, one-cycle pulses
    typedef struct packed {
        logic halt;         // user halt request
        logic run;          // run directive
        logic step;         // single-step directive
        logic step_permit;  // step_interrupt_permit, read with step
    } dbx_cmd_s;

    // configuration levels
    typedef struct packed {
        logic stop_mode_en; // stop mode debug enabled
        logic sync_run_en;  // run waits for the global sync
        logic trig_en;      // external triggers may halt
        logic wp_en;        // watchpoints may halt
    } dbx_cfg_s;

    // raw pins from outside the clock domain
    typedef struct packed {
        logic dbg_conn;     // debugger attached
        logic gsync;        // global synchronisation signal
        logic trig;         // external device-level trigger
    } dbx_pin_s;

    // cause of the last break
    typedef struct packed {
        logic user;
        logic swbp;
        logic hwbp;
        logic wp;
        logic trig;
    } dbx_cause_s;

endpackage : dbx_pkg

// file: tb/dbx_pipe_model.sv
// dbx_pipe_model: pipeline front end that feeds packets toward stage two
// assumes one clk domain; the debugger picks the soft halt address
`timescale 1ns/100ps
`default_nettype none

module dbx_pipe_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        load,         // flush and restart at start_pc
    input  wire logic [15:0] start_pc,
    input  wire logic [15:0] soft_pc,      // where the halt opcode sits
    input  wire logic        d2_go,
    output logic             d2_valid,
    output logic [15:0]      d2_pc,
    output logic             d2_soft_halt,
    output logic             ib_boundary
);
    logic [15:0] pc_q;    // address of the waiting packet
    logic        live_q;  // a program has been loaded
    logic        busy_q;  // packet in flight, no boundary

    // candidate is held until the block lets it go
    always_ff @(posedge clk) begin
        if (rst) begin
            pc_q   <= 16'h0000;
            live_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            busy_q <= d2_go;
            if (load) begin
                pc_q   <= start_pc;
                live_q <= 1'b1;
            end else if (d2_go) begin
                pc_q <= pc_q + 16'h0001;
            end
        end
    end

    assign d2_valid = live_q;
    // idle bus shows the inverse so a stale value never passes
    assign d2_pc = live_q ? pc_q : ~pc_q;
    assign d2_soft_halt = live_q && (pc_q == soft_pc);
    assign ib_boundary = ~busy_q;
endmodule : dbx_pipe_model

`default_nettype wire

// file: tb/tb_top.sv
// tb_top: self-checking bench for the execution control block
// assumes the pipeline model stands on the far side of the block
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    typedef struct packed {
        dbx_pkg::dbx_cfg_s   cfg;   // configuration of the row
        logic [3:0]          src;   // {dbg_conn, halt, wp, trig}
        logic [1:0]          ce;
        logic [15:0]         rf;
        logic [15:0]         mk;
        logic [15:0]         sw;
        logic                exp_h;
        dbx_pkg::dbx_cause_s exp_c;
        logic [1:0]          exp_b;
    } dbx_row_s;

    logic clk, rst, wp_req, int_busy, load, d2_valid, d2_soft_halt, ib_boundary;
    logic d2_go, int_svc, int_lost, running, halted, stepping, sync_wait, free_run;
    dbx_pkg::dbx_cmd_s   cmd;
    dbx_pkg::dbx_cfg_s   cfg;
    dbx_pkg::dbx_pin_s   pins;
    dbx_pkg::dbx_cause_s cause;
    logic [3:0]          int_req, int_ack, int_pend;
    logic [1:0]          cmp_en, bp_hit;
    logic [1:0][15:0]    cmp_ref, cmp_mask;
    logic [15:0]         soft_pc, d2_pc;
    dbx_row_s            rows [10];
    int bad_count = 0;
    int checks_done = 0;
    int go_cnt = 0;
    int base, p, i;

    dbx_exec_ctrl #(.ADDR_W(16), .NUM_CMP(2), .NUM_INT(4)) i_dbx_exec_ctrl (
        .clk(clk), .rst(rst), .cmd(cmd), .cfg(cfg), .pins(pins), .wp_req(wp_req),
        .d2_valid(d2_valid), .d2_pc(d2_pc), .d2_soft_halt(d2_soft_halt),
        .ib_boundary(ib_boundary), .int_busy(int_busy), .int_req(int_req),
        .int_ack(int_ack), .cmp_en(cmp_en), .cmp_ref(cmp_ref), .cmp_mask(cmp_mask),
        .d2_go(d2_go), .int_svc(int_svc), .int_pend(int_pend), .int_lost(int_lost),
        .running(running), .halted(halted), .stepping(stepping),
        .sync_wait(sync_wait), .free_run(free_run), .cause(cause), .bp_hit(bp_hit));

    dbx_pipe_model i_dbx_pipe_model (
        .clk(clk), .rst(rst), .load(load), .start_pc(16'h0100), .soft_pc(soft_pc),
        .d2_go(d2_go), .d2_valid(d2_valid), .d2_pc(d2_pc),
        .d2_soft_halt(d2_soft_halt), .ib_boundary(ib_boundary));

    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // packets let into stage two
    always @(posedge clk) begin
        if (d2_go === 1'b1) go_cnt <= go_cnt + 1;
    end

    task conclude;
        $display("counts: %0d checks, %0d mismatches", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    task chk1(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : chk1

    task chkv(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : chkv

    task waitc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : waitc

    // one-cycle debugger command, seen at the second edge
    task go(input dbx_pkg::dbx_cmd_s c);
        @(posedge clk);
        cmd <= c;
        @(posedge clk);
        cmd <= '0;
        #1;
    endtask : go

    task wait_halt;
        for (int k = 0; k < 40 && halted !== 1'b1; k++) waitc(1);
    endtask : wait_halt

    task pulse_int(input logic [3:0] r, input logic [3:0] a);
        @(posedge clk);
        int_req <= r;
        int_ack <= a;
        @(posedge clk);
        int_req <= '0;
        int_ack <= '0;
        #1;
    endtask : pulse_int

    // clear all break sources, then stop the core with a user halt
    task back_to_halt;
        @(posedge clk);
        {wp_req, pins.trig, pins.dbg_conn, cmp_en, soft_pc} <= {3'b001, 2'b00, 16'hFFFF};
        cfg <= 4'h8;
        waitc(4);
        if (halted !== 1'b1) go(4'h8);
        wait_halt;
        chk1(halted, 1'b1, "back to halt");
    endtask : back_to_halt

    task run_row(input dbx_row_s r);
        @(posedge clk);
        cfg <= r.cfg;
        pins.dbg_conn <= r.src[3];
        {cmp_en, cmp_ref, cmp_mask, soft_pc} <= {r.ce, r.rf, r.rf, r.mk, r.mk, r.sw};
        load <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
        go(4'h4);
        waitc(3);
        @(posedge clk);
        {cmd.halt, wp_req, pins.trig} <= r.src[2:0];
        @(posedge clk);
        cmd.halt <= 1'b0;
        waitc(14);
        chk1(halted, r.exp_h, "break outcome");
        if (r.exp_h) chkv(16'(cause), 16'(r.exp_c), "break cause");
        if (r.exp_c.hwbp) chkv(16'(bp_hit), 16'(r.exp_b), "comparator hits");
        if (r.exp_c.hwbp) chk1((d2_pc & ~r.mk) == (r.rf & ~r.mk), 1'b1, "held match");
        if (r.exp_c.swbp) chkv(d2_pc, r.sw, "soft halt packet held");
        back_to_halt;
    endtask : run_row

    // a hang ends the run the same way as the tests
    initial begin
        #(4 * 6000);
        bad_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        conclude;
    end

    initial begin
        {rst, cmd, cfg, pins, wp_req, int_busy, int_req, int_ack} = {1'b1, 4'h0, 4'h8, 3'h4, 10'h0};
        {cmp_en, cmp_ref, cmp_mask, load, soft_pc} = {67'h0, 16'hFFFF};
        rows = '{'{4'h8, 4'hC, 2'h0, 16'h0, 16'h0, 16'hFFFF, 1'b1, 5'h10, 2'h0},
                 '{4'h9, 4'hA, 2'h0, 16'h0, 16'h0, 16'hFFFF, 1'b1, 5'h02, 2'h0},
                 '{4'h8, 4'hA, 2'h0, 16'h0, 16'h0, 16'hFFFF, 1'b0, 5'h00, 2'h0},
                 '{4'hA, 4'h9, 2'h0, 16'h0, 16'h0, 16'hFFFF, 1'b1, 5'h01, 2'h0},
                 '{4'h8, 4'h9, 2'h0, 16'h0, 16'h0, 16'hFFFF, 1'b0, 5'h00, 2'h0},
                 '{4'h8, 4'h8, 2'h2, 16'h0103, 16'h0, 16'hFFFF, 1'b1, 5'h04, 2'h2},
                 '{4'h8, 4'h8, 2'h1, 16'h01F0, 16'h00F0, 16'hFFFF, 1'b1, 5'h04, 2'h1},
                 '{4'h8, 4'h8, 2'h3, 16'h0180, 16'h0070, 16'hFFFF, 1'b0, 5'h00, 2'h0},
                 '{4'h8, 4'h8, 2'h0, 16'h0, 16'h0, 16'h0102, 1'b1, 5'h08, 2'h0},
                 '{4'h8, 4'h0, 2'h0, 16'h0, 16'h0, 16'h0102, 1'b0, 5'h00, 2'h0}};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        waitc(1);
        chk1(running, 1'b1, "reset running");
        chk1(int_svc, 1'b1, "reset int_svc");
        chkv({halted, stepping, sync_wait, free_run, int_lost, int_pend}, 16'h0, "reset outputs");
        $display("test reset done");
        @(posedge clk);
        load <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
        go(4'h8);
        wait_halt;
        chk1(halted, 1'b1, "first halt");
        foreach (rows[j]) begin
            run_row(rows[j]);
            $display("test row %0d done", j);
        end
        // interrupts seen while halted are only recorded
        chk1(int_svc, 1'b0, "halt gates interrupts");
        pulse_int(4'h4, 4'h0);
        chkv(16'(int_pend), 16'h4, "pending set");
        chk1(int_lost, 1'b0, "first request kept");
        pulse_int(4'h4, 4'h0);
        chk1(int_lost, 1'b1, "second request lost");
        pulse_int(4'h1, 4'h0);
        chkv(16'(int_pend), 16'h5, "reset request pending");
        chk1(halted, 1'b1, "reset request ignored");
        pulse_int(4'h0, 4'h5);
        chkv(16'(int_pend), 16'h0, "ack clears");
        $display("test interrupts done");
        for (p = 0; p < 2; p++) begin
            base = go_cnt;
            go(p[0] ? 4'h3 : 4'h2);
            chk1(stepping, 1'b1, "stepping");
            chk1(int_svc, p[0], "step permit");
            wait_halt;
            chk1(halted, 1'b1, "step back to halt");
            chkv(16'(go_cnt - base), 16'h1, "one packet per step");
        end
        $display("test step done");
        @(posedge clk);
        {cfg, cmp_en, cmp_mask} <= {4'h1, 2'h1, 32'hFFFFFFFF};
        go(4'h4);
        chk1(free_run, 1'b1, "free run entered");
        chk1(int_svc, 1'b1, "free run services");
        @(posedge clk);
        wp_req <= 1'b1;
        waitc(10);
        chk1(free_run, 1'b1, "breaks ignored");
        back_to_halt;
        $display("test free run done");
        @(posedge clk);
        cfg <= 4'hC;
        go(4'h4);
        waitc(5);
        chk1(sync_wait, 1'b1, "waiting for sync");
        chk1(running, 1'b0, "not yet running");
        @(posedge clk);
        pins.gsync <= 1'b1;
        for (i = 0; i < 8 && running !== 1'b1; i++) waitc(1);
        chk1(running, 1'b1, "run after sync");
        chk1(int_svc, 1'b1, "run services");
        @(posedge clk);
        {pins.gsync, cfg, int_busy} <= {1'b0, 4'h8, 1'b1};
        go(4'h8);
        waitc(6);
        chk1(halted, 1'b0, "halt deferred");
        @(posedge clk);
        int_busy <= 1'b0;
        wait_halt;
        chk1(halted, 1'b1, "halt after entry");
        $display("test sync and defer done");
        // a second reset from halt brings back the run state
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        waitc(1);
        chk1(running, 1'b1, "reset again running");
        chk1(int_svc, 1'b1, "reset again int_svc");
        chkv({halted, free_run, int_pend, int_lost, d2_go}, 16'h0, "reset again idle");
        $display("test mid-run reset done");
        conclude;
    end
endmodule : tb_top

`default_nettype wire
